/* hdl/sfr_bank0_pkg.sv */
// constants for the bank 0 special-function register map
package sfr_bank0_pkg;

    // ----------------------------------------------------------------
    // bus and address map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_SLOTS = 32;
    localparam logic [7:0] PC_LOW_ADDR = 8'h02;
    localparam logic [7:0] PORT_D_ADDR = 8'h08;
    localparam logic [7:0] PORT_E_ADDR = 8'h09;
    localparam logic [7:0] PC_UPPER_ADDR = 8'h0a;
    localparam logic [7:0] INT_CTRL_ADDR = 8'h0b;
    localparam logic [7:0] IRQ_FLAGS1_ADDR = 8'h0c;
    localparam logic [7:0] IRQ_FLAGS2_ADDR = 8'h0d;
    localparam logic [7:0] T1_LOW_ADDR = 8'h0e;
    localparam logic [7:0] T1_HIGH_ADDR = 8'h0f;
    localparam logic [7:0] T1_CTRL_ADDR = 8'h10;
    localparam logic [7:0] T2_COUNT_ADDR = 8'h11;
    localparam logic [7:0] T2_CTRL_ADDR = 8'h12;
    localparam logic [7:0] SER_BUF_ADDR = 8'h13;
    localparam logic [7:0] SER_CTRL_ADDR = 8'h14;
    localparam logic [7:0] CAP1_LOW_ADDR = 8'h15;
    localparam logic [7:0] CAP1_HIGH_ADDR = 8'h16;
    localparam logic [7:0] CAP1_CTRL_ADDR = 8'h17;
    localparam logic [7:0] UART_STAT_ADDR = 8'h18;
    localparam logic [7:0] UART_TX_ADDR = 8'h19;
    localparam logic [7:0] UART_RX_ADDR = 8'h1a;
    localparam logic [7:0] CAP2_LOW_ADDR = 8'h1b;
    localparam logic [7:0] CAP2_HIGH_ADDR = 8'h1c;
    localparam logic [7:0] CAP2_CTRL_ADDR = 8'h1d;
    localparam logic [7:0] ADC_HIGH_ADDR = 8'h1e;
    localparam logic [7:0] ADC_CTRL_ADDR = 8'h1f;
    localparam logic [7:0] SLAVE_ADDR_ADDR = 8'h93;
    localparam logic [7:0] EVT_STATUS_ADDR = 8'h7d;
    localparam logic [7:0] EVT_ENABLE_ADDR = 8'h7e;
    localparam logic [7:0] EVT_CLEAR_ADDR = 8'h7f;

    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    localparam int PORT_CHANGE_BIT = 0;
    localparam logic [3:0] MASK_MODE = 4'h9;
    localparam logic [7:0] SLAVE_ADDR_RESET = 8'h00;
    localparam logic [7:0] ADDR_MASK_RESET = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int EVT_W = 4;
    localparam int EVT_PORT_CHANGE = 0;
    localparam int EVT_RX_LOADED = 1;
    localparam int EVT_ADC_LOADED = 2;
    localparam int EVT_CAP2_LOADED = 3;
    localparam int PORT_E_ANALOG_LSB = 5;

    // implemented bits per slot, zero where nothing is there
    localparam logic [7:0] IMPL_MASK [0:31] = '{
        8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'hff, 8'h0f, 8'h1f, 8'hff, 8'h7f, 8'hfd, 8'hff, 8'hff,
        8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff};
    // slots that hold their value through a warm reset
    localparam logic [31:0] KEEP_WARM = 32'h5868_c300;
    // slots that software may write
    localparam logic [31:0] SW_WRITABLE = 32'hbbff_ff04;

endpackage

/* hdl/sfr_byte_reg.sv */
// one special-function byte with cold and warm reset behaviour
`timescale 1ns/1ps
module sfr_byte_reg #(
    parameter logic [7:0] MASK = 8'hff,
    parameter bit KEEP = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cold_reset,
    // software write
    input wire logic sw_wr,
    input wire logic [7:0] sw_data,
    // hardware load, wins over software
    input wire logic hw_ld,
    input wire logic [7:0] hw_data,
    // contents
    output logic [7:0] q
);
    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic clear_now;
    assign clear_now = cold_reset || !KEEP;

    // warm reset holds kept bytes, cold reset always clears
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            if (clear_now) begin
                q <= 8'h00;
            end
        end else if (hw_ld) begin
            q <= hw_data & MASK;
        end else if (sw_wr) begin
            q <= sw_data & MASK;
        end
    end
endmodule

/* hdl/sfr_bank0.sv */
// bank 0 special-function register file with reset-type aware storage
//
// How it works
// - unimplemented bits and slots read zero, ignore writes
// - warm reset keeps port data latches
// - any reset clears port-change flag, mismatch sets it again
// - mode 1001 redirects slave-address access to mask
// - analog-selected port pins read zero
// - uart receive holding clears on every reset
// - capture 2 low byte kept on warm reset
// - converter result high kept on warm reset
// - timer 1 low byte own register, warm kept
// - timer 1 high byte own register, warm kept
// - program counter low clears on every reset
`timescale 1ns/1ps
module sfr_bank0 (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cold_reset,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    // port pins
    input wire logic [7:0] port_d_pin,
    input wire logic [3:0] port_e_pin,
    input wire logic [7:0] analog_select_low,
    input wire logic [5:0] analog_select_high,
    output logic [7:0] port_d_latch,
    output logic [3:0] port_e_latch,
    // peripheral side
    input wire logic port_mismatch,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic adc_done,
    input wire logic [7:0] adc_result,
    input wire logic cap2_load,
    input wire logic [7:0] cap2_value,
    output logic tx_load,
    output logic [7:0] tx_data,
    // interrupt
    output logic irq
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [7:0] port_d_meta_q;
    logic [7:0] port_d_sync_q;
    logic [3:0] port_e_meta_q;
    logic [3:0] port_e_sync_q;

    // two flops per pin, the first read only by the second
    always_ff @(posedge clk) begin
        port_d_meta_q <= port_d_pin;
        port_d_sync_q <= port_d_meta_q;
        port_e_meta_q <= port_e_pin;
        port_e_sync_q <= port_e_meta_q;
    end

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    logic [7:0] reg_q [0:31];
    logic [31:0] hw_ld;
    logic [7:0] hw_data [0:31];
    logic in_bank0;
    logic slave_hit;
    logic mask_mode;
    logic status_hit;
    logic enable_hit;
    logic clear_hit;

    assign in_bank0 = (addr[7:5] == 3'b000);
    assign slave_hit = (addr == sfr_bank0_pkg::SLAVE_ADDR_ADDR);
    assign mask_mode = (reg_q[5'h14][3:0] == sfr_bank0_pkg::MASK_MODE);
    assign status_hit = (addr == sfr_bank0_pkg::EVT_STATUS_ADDR);
    assign enable_hit = (addr == sfr_bank0_pkg::EVT_ENABLE_ADDR);
    assign clear_hit = (addr == sfr_bank0_pkg::EVT_CLEAR_ADDR);

    // ----------------------------------------------------------------
    // hardware loads
    // ----------------------------------------------------------------
    logic int_wr;
    logic [7:0] int_base;

    // flag set by mismatch wins over a write clearing it
    assign int_wr = wr_en && (addr == sfr_bank0_pkg::INT_CTRL_ADDR);
    assign int_base = int_wr ? wr_data : reg_q[5'h0b];

    always_comb begin
        hw_ld = 32'h0000_0000;
        for (int k = 0; k < 32; k++) begin
            hw_data[k] = 8'h00;
        end
        hw_ld[5'h0b] = port_mismatch;
        hw_data[5'h0b] = int_base | (8'h01 << sfr_bank0_pkg::PORT_CHANGE_BIT);
        hw_ld[5'h1a] = rx_valid;
        hw_data[5'h1a] = rx_data;
        hw_ld[5'h1e] = adc_done;
        hw_data[5'h1e] = adc_result;
        hw_ld[5'h1b] = cap2_load;
        hw_data[5'h1b] = cap2_value;
    end

    // ----------------------------------------------------------------
    // register slots
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : slot
            if (sfr_bank0_pkg::IMPL_MASK[g] != 8'h00) begin : impl
                logic sw_wr;
                assign sw_wr = wr_en && in_bank0 && (addr[4:0] == 5'(g)) &&
                               sfr_bank0_pkg::SW_WRITABLE[g];
                sfr_byte_reg #(
                    .MASK(sfr_bank0_pkg::IMPL_MASK[g]),
                    .KEEP(sfr_bank0_pkg::KEEP_WARM[g])
                ) u_reg (
                    .clk(clk),
                    .sys_rst(sys_rst),
                    .cold_reset(cold_reset),
                    .sw_wr(sw_wr),
                    .sw_data(wr_data),
                    .hw_ld(hw_ld[g]),
                    .hw_data(hw_data[g]),
                    .q(reg_q[g])
                );
            end else begin : empty
                assign reg_q[g] = 8'h00;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // serial slave address and its mask
    // ----------------------------------------------------------------
    logic [7:0] slave_addr_q;
    logic [7:0] addr_mask_q;
    logic slave_wr;
    logic mask_wr;

    // mode 1001 steers the shared location to the mask
    assign slave_wr = wr_en && slave_hit && !mask_mode;
    assign mask_wr = wr_en && slave_hit && mask_mode;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slave_addr_q <= sfr_bank0_pkg::SLAVE_ADDR_RESET;
            addr_mask_q <= sfr_bank0_pkg::ADDR_MASK_RESET;
        end else begin
            if (slave_wr) begin
                slave_addr_q <= wr_data;
            end
            if (mask_wr) begin
                addr_mask_q <= wr_data;
            end
        end
    end

    // ----------------------------------------------------------------
    // event status, enable and interrupt
    // ----------------------------------------------------------------
    logic [3:0] evt_status_q;
    logic [3:0] evt_status_d;
    logic [3:0] evt_enable_q;
    logic [3:0] evt_set;
    logic [3:0] evt_clr;

    assign evt_set = {cap2_load, adc_done, rx_valid, port_mismatch};
    assign evt_clr = (wr_en && clear_hit) ? wr_data[3:0] : 4'h0;
    // set wins over clear in the same cycle
    assign evt_status_d = (evt_status_q & ~evt_clr) | evt_set;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            evt_status_q <= 4'h0;
            evt_enable_q <= 4'h0;
            irq <= 1'b0;
        end else begin
            evt_status_q <= evt_status_d;
            if (wr_en && enable_hit) begin
                evt_enable_q <= wr_data[3:0];
            end
            irq <= |(evt_status_d & ((wr_en && enable_hit) ? wr_data[3:0] : evt_enable_q));
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [3:0] port_e_analog;
    logic [7:0] port_d_view;
    logic [7:0] port_e_view;
    logic [7:0] bank0_view;
    logic [7:0] rd_value;

    // analog pins read zero, port d carries no analog function
    assign port_e_analog = {1'b0, analog_select_low[sfr_bank0_pkg::PORT_E_ANALOG_LSB +: 3]};
    assign port_d_view = port_d_sync_q;
    assign port_e_view = {4'h0, port_e_sync_q & ~port_e_analog};
    // pins read instead of latches, the write-only slot reads zero
    assign bank0_view = (addr[4:0] == 5'h08) ? port_d_view :
                        (addr[4:0] == 5'h09) ? port_e_view :
                        (addr[4:0] == 5'h19) ? 8'h00 : reg_q[addr[4:0]];
    assign rd_value = in_bank0 ? bank0_view :
                      slave_hit ? (mask_mode ? addr_mask_q : slave_addr_q) :
                      status_hit ? {4'h0, evt_status_q} :
                      enable_hit ? {4'h0, evt_enable_q} : 8'h00;

    // data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_en ? rd_value : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // transmit strobe and latch outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_load <= 1'b0;
        end else begin
            tx_load <= wr_en && (addr == sfr_bank0_pkg::UART_TX_ADDR);
        end
    end

    assign tx_data = reg_q[5'h19];
    assign port_d_latch = reg_q[5'h08];
    assign port_e_latch = reg_q[5'h09][3:0];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_unimpl_read_zero: assert property (@(posedge clk) disable iff (sys_rst)
        rd_en && (addr == 8'h05 || addr == 8'h40) |=> rd_data == 8'h00)
        else $error("unimplemented slot read non-zero");

    a_unimpl_bits_zero: assert property (@(posedge clk) disable iff (sys_rst)
        wr_en && addr == sfr_bank0_pkg::PC_UPPER_ADDR |=> reg_q[5'h0a][7:5] == 3'b000)
        else $error("unimplemented bits took a write");

    a_port_latch_kept: assert property (@(posedge clk)
        sys_rst && !cold_reset |=> port_d_latch == $past(port_d_latch))
        else $error("port latch changed on warm reset");

    a_port_e_kept: assert property (@(posedge clk)
        sys_rst && !cold_reset |=> port_e_latch == $past(port_e_latch))
        else $error("port e latch changed on warm reset");

    a_flag_reset_clear: assert property (@(posedge clk)
        sys_rst |=> reg_q[5'h0b][0] == 1'b0)
        else $error("port-change flag survived reset");

    // the release edge still samples reset high, so it must not arm the check
    a_flag_sets_again: assert property (@(posedge clk) disable iff (sys_rst)
        port_mismatch && !sys_rst |=> reg_q[5'h0b][0] && evt_status_q[0])
        else $error("port-change flag did not set on mismatch");

    a_mask_redirect: assert property (@(posedge clk) disable iff (sys_rst)
        wr_en && slave_hit && mask_mode |=> addr_mask_q == $past(wr_data) &&
        slave_addr_q == $past(slave_addr_q))
        else $error("masked mode write missed the mask");

    a_slave_write_plain: assert property (@(posedge clk) disable iff (sys_rst)
        wr_en && slave_hit && !mask_mode |=> slave_addr_q == $past(wr_data) &&
        addr_mask_q == $past(addr_mask_q))
        else $error("plain mode write missed the slave address");

    a_mask_read_view: assert property (@(posedge clk) disable iff (sys_rst)
        rd_en && slave_hit && mask_mode |=> rd_data == $past(addr_mask_q))
        else $error("masked mode read missed the mask");

    a_analog_read_zero: assert property (@(posedge clk) disable iff (sys_rst)
        rd_en && addr == 8'h09 && analog_select_low[5] |=> rd_data[0] == 1'b0)
        else $error("analog pin read non-zero");

    a_rx_reset_zero: assert property (@(posedge clk)
        sys_rst |=> reg_q[5'h1a] == 8'h00)
        else $error("receive holding not cleared by reset");

    a_cap2_warm_kept: assert property (@(posedge clk)
        sys_rst && !cold_reset |=> reg_q[5'h1b] == $past(reg_q[5'h1b]))
        else $error("capture 2 low changed on warm reset");

    a_result_warm_kept: assert property (@(posedge clk)
        sys_rst && !cold_reset |=> reg_q[5'h1e] == $past(reg_q[5'h1e]))
        else $error("converter result changed on warm reset");

    a_t1_low_kept: assert property (@(posedge clk)
        sys_rst && !cold_reset |=> reg_q[5'h0e] == $past(reg_q[5'h0e]))
        else $error("timer 1 low changed on warm reset");

    a_t1_high_kept: assert property (@(posedge clk)
        sys_rst && !cold_reset |=> reg_q[5'h0f] == $past(reg_q[5'h0f]))
        else $error("timer 1 high changed on warm reset");

    a_pc_low_clear: assert property (@(posedge clk)
        sys_rst |=> reg_q[5'h02] == 8'h00)
        else $error("program counter low not cleared");

    a_cold_clears_kept: assert property (@(posedge clk)
        sys_rst && cold_reset |=> reg_q[5'h0e] == 8'h00 && reg_q[5'h08] == 8'h00)
        else $error("cold reset left a kept byte");

    a_warm_clears_plain: assert property (@(posedge clk)
        sys_rst && !cold_reset |=> reg_q[5'h0d] == 8'h00 && reg_q[5'h14] == 8'h00)
        else $error("warm reset left a cleared byte");

    a_decode_readback: assert property (@(posedge clk) disable iff (sys_rst)
        wr_en && addr == 8'h10 ##2 rd_en && addr == 8'h10 |=> rd_data == $past(wr_data, 3))
        else $error("written register read back wrong");

    a_rd_idle_zero: assert property (@(posedge clk) disable iff (sys_rst)
        !rd_en |=> rd_data == 8'h00)
        else $error("read data stood without a read");

    a_tx_load_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        wr_en && addr == sfr_bank0_pkg::UART_TX_ADDR |=> tx_load && tx_data == $past(wr_data))
        else $error("transmit write gave no load pulse");

    a_tx_load_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !(wr_en && addr == sfr_bank0_pkg::UART_TX_ADDR) |=> !tx_load)
        else $error("load pulse without a transmit write");

    a_rx_load_value: assert property (@(posedge clk) disable iff (sys_rst)
        rx_valid && !sys_rst |=> reg_q[5'h1a] == $past(rx_data))
        else $error("receive byte not loaded");

    a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
        irq == |(evt_status_q & evt_enable_q))
        else $error("interrupt level disagrees with status and enable");

    c_mask_write: cover property (@(posedge clk) disable iff (sys_rst) mask_wr);
    c_irq_rise: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq));
    c_warm_reset: cover property (@(posedge clk) sys_rst && !cold_reset);
    c_set_and_clear: cover property (@(posedge clk) disable iff (sys_rst)
        port_mismatch && wr_en && clear_hit && wr_data[0]);
endmodule

/* sim/sfr_bank0_bench.sv */
// self-checking bench for the bank 0 special-function register file
`timescale 1ns/1ps
module sfr_bank0_bench;
    // ----------------------------------------------------------------
    // stimulus, clock and design
    // ----------------------------------------------------------------
    typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e; logic k;} row_type;
    // address, write value, read-back, kept through a warm reset
    localparam row_type ROWS [0:21] = '{
        '{8'h02, 8'ha5, 8'ha5, 1'b0}, '{8'h0a, 8'hff, 8'h1f, 1'b0}, '{8'h0c, 8'hff, 8'h7f, 1'b0},
        '{8'h0d, 8'hff, 8'hfd, 1'b0}, '{8'h0e, 8'h3c, 8'h3c, 1'b1}, '{8'h0f, 8'hc3, 8'hc3, 1'b1},
        '{8'h10, 8'h55, 8'h55, 1'b0}, '{8'h11, 8'h66, 8'h66, 1'b0}, '{8'h12, 8'hff, 8'h7f, 1'b0},
        '{8'h13, 8'h5a, 8'h5a, 1'b1}, '{8'h15, 8'h11, 8'h11, 1'b1}, '{8'h16, 8'h22, 8'h22, 1'b1},
        '{8'h17, 8'h33, 8'h33, 1'b0}, '{8'h18, 8'h44, 8'h44, 1'b0}, '{8'h1b, 8'h77, 8'h77, 1'b1},
        '{8'h1c, 8'h88, 8'h88, 1'b1}, '{8'h1d, 8'hff, 8'h3f, 1'b0}, '{8'h1f, 8'h99, 8'h99, 1'b0},
        '{8'h05, 8'hff, 8'h00, 1'b0}, '{8'h1a, 8'hff, 8'h00, 1'b0}, '{8'h20, 8'hff, 8'h00, 1'b0},
        '{8'h01, 8'hff, 8'h00, 1'b0}};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cold_reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rd_data;
    logic [7:0] port_d_pin = 8'h00;
    logic [3:0] port_e_pin = 4'hf;
    logic [7:0] analog_select_low = 8'h00;
    logic [7:0] port_d_latch;
    logic [3:0] port_e_latch;
    logic port_mismatch = 1'b0;
    logic rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic adc_done = 1'b0;
    logic [7:0] adc_result = 8'h00;
    logic cap2_load = 1'b0;
    logic [7:0] cap2_value = 8'h00;
    logic tx_load;
    logic [7:0] tx_data;
    logic irq;
    int num_errors = 0;
    int tests_run = 0;

    // 50 ns clock
    always #25 clk = ~clk;

    sfr_bank0 i_dut (
        .clk(clk), .sys_rst(sys_rst), .cold_reset(cold_reset),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .port_d_pin(port_d_pin), .port_e_pin(port_e_pin), .analog_select_low(analog_select_low),
        .analog_select_high(6'h00), .port_d_latch(port_d_latch), .port_e_latch(port_e_latch),
        .port_mismatch(port_mismatch), .rx_valid(rx_valid), .rx_data(rx_data),
        .adc_done(adc_done), .adc_result(adc_result), .cap2_load(cap2_load),
        .cap2_value(cap2_value), .tx_load(tx_load), .tx_data(tx_data), .irq(irq)
    );

    // ----------------------------------------------------------------
    // compare, bus and reporting tasks
    // ----------------------------------------------------------------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    // one-cycle write strobe, released the edge it is taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string what);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk_byte(rd_data, e, what);
    endtask

    // one-cycle peripheral event: 1 receive, 2 converter, 3 capture
    task automatic ev(input int k, input logic [7:0] v);
        @(posedge clk);
        rx_data <= v;
        adc_result <= v;
        cap2_value <= v;
        rx_valid <= (k == 1);
        adc_done <= (k == 2);
        cap2_load <= (k == 3);
        @(posedge clk);
        rx_valid <= 1'b0;
        adc_done <= 1'b0;
        cap2_load <= 1'b0;
        #1;
    endtask

    task automatic do_reset(input logic cold);
        @(posedge clk);
        sys_rst <= 1'b1;
        cold_reset <= cold;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // watchdog, about sixty-eight times the expected run
    // ----------------------------------------------------------------
    initial begin
        #1_000_000;
        num_errors++;
        $display("mismatch t=%0t watchdog expired", $time);
        final_report();
    end

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        cold_reset <= 1'b0;
        // table: write then read back every row
        foreach (ROWS[i]) begin
            wr(ROWS[i].a, ROWS[i].w);
            rd_chk(ROWS[i].a, ROWS[i].e, "table readback");
        end
        $display("test table done");
        // pins read through the synchroniser, analog pins read zero
        port_d_pin <= 8'h3c;
        analog_select_low <= 8'he0;
        repeat (4) @(posedge clk);
        rd_chk(8'h08, 8'h3c, "port d pins");
        rd_chk(8'h09, 8'h08, "port e analog");
        analog_select_low <= 8'h00;
        rd_chk(8'h09, 8'h0f, "port e digital");
        wr(8'h08, 8'ha5);
        wr(8'h09, 8'h0a);
        #1;
        chk_byte(port_d_latch, 8'ha5, "port d latch");
        chk_byte({4'h0, port_e_latch}, 8'h0a, "port e latch");
        $display("test pins done");
        // transmit holding is write-only with a load pulse
        wr(8'h19, 8'hc7);
        #1;
        chk_bit(tx_load, 1'b1, "tx pulse");
        chk_byte(tx_data, 8'hc7, "tx data");
        @(posedge clk);
        #1;
        chk_bit(tx_load, 1'b0, "tx pulse end");
        rd_chk(8'h19, 8'h00, "tx reads zero");
        $display("test tx done");
        // slave address and its mask share one location
        wr(8'h93, 8'h12);
        wr(8'h14, 8'h09);
        rd_chk(8'h93, 8'hff, "mask reset value");
        wr(8'h93, 8'h0f);
        rd_chk(8'h93, 8'h0f, "mask written");
        wr(8'h14, 8'h00);
        rd_chk(8'h93, 8'h12, "slave address kept");
        $display("test redirect done");
        // events: raise, mask, clear
        wr(8'h7e, 8'h0a);
        ev(1, 8'h5e);
        chk_bit(irq, 1'b1, "rx irq");
        rd_chk(8'h7d, 8'h02, "rx status");
        rd_chk(8'h1a, 8'h5e, "rx holding");
        wr(8'h7f, 8'h02);
        #1;
        chk_bit(irq, 1'b0, "rx cleared");
        ev(2, 8'hd4);
        chk_bit(irq, 1'b0, "adc masked");
        rd_chk(8'h7d, 8'h04, "adc status");
        rd_chk(8'h1e, 8'hd4, "adc result");
        ev(3, 8'hb6);
        chk_bit(irq, 1'b1, "cap2 irq");
        rd_chk(8'h1b, 8'hb6, "cap2 loaded");
        wr(8'h7f, 8'h0f);
        wr(8'h1e, 8'h3c);
        wr(8'h1b, 8'h77);
        #1;
        chk_bit(irq, 1'b0, "all cleared");
        rd_chk(8'h1e, 8'hd4, "read-only ignores write");
        $display("test events done");
        // warm reset with a pin mismatch standing
        port_mismatch <= 1'b1;
        do_reset(1'b0);
        rd_chk(8'h0b, 8'h01, "port change flag back");
        rd_chk(8'h7d, 8'h01, "port change status");
        wr(8'h0b, 8'h00);
        rd_chk(8'h0b, 8'h01, "flag set wins over write");
        foreach (ROWS[i]) begin
            rd_chk(ROWS[i].a, ROWS[i].k ? ROWS[i].e : 8'h00, "warm value");
        end
        rd_chk(8'h1e, 8'hd4, "adc warm");
        chk_byte(port_d_latch, 8'ha5, "port d latch warm");
        chk_byte({4'h0, port_e_latch}, 8'h0a, "port e latch warm");
        $display("test warm reset done");
        // cold reset clears every byte, the mask returns to ff
        port_mismatch <= 1'b0;
        do_reset(1'b1);
        rd_chk(8'h0b, 8'h00, "flag cold");
        foreach (ROWS[i]) begin
            rd_chk(ROWS[i].a, 8'h00, "cold value");
        end
        rd_chk(8'h1e, 8'h00, "adc cold");
        chk_byte(port_d_latch, 8'h00, "port d latch cold");
        rd_chk(8'h93, 8'h00, "slave address cold");
        wr(8'h14, 8'h09);
        rd_chk(8'h93, 8'hff, "mask cold");
        $display("test cold reset done");
        final_report();
    end
endmodule
